// ===== src/codec_serial_frame.sv
// Codec serial port framing: frame syncs, end strobe, data shifting and control bit mirror.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "codec_serial_regs.svh"

// Function
// - In dual-word mode the auxiliary output mirrors control bit eleven.
// - Reset clears control bit eleven so the auxiliary output starts low.
// - In dual-word mode the auxiliary output follows a write to bit eleven on the next cycle.
// - Word format: one low pulse on receive end strobe after sixteen bits.
// - Byte format: end strobe low after first byte until second byte sent.
// - Secondary frame sync stays high through every primary frame.
// - Dual-word secondary frame: secondary sync copies transmit frame sync.
// - Receive frame sync stays low while result bits are shifted out.
// - Most significant result bit is on the data line before receive sync falls.
// - Transmit frame sync stays low while the host shifts data in.
// - Bits on both data lines move with the supplied shift clock.
module codec_serial_frame (
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// Register port.
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	// Mode straps.
	input  wire logic        mode_ctrl_i,
	input  wire logic        word_byte_sel_i,
	// Serial link.
	input  wire logic        serial_data_in_i,
	output logic             serial_data_out_o,
	output logic             shift_clk_o,
	output logic             receive_frame_sync_n_o,
	output logic             transmit_frame_sync_n_o,
	output logic             secondary_frame_sync_o,
	output logic             receive_end_strobe_n_o,
	output logic             aux_output_hi_o,
	// Interrupt.
	output logic             irq_o
);

	codec_serial_pkg::frame_state_t st_q;
	codec_serial_pkg::frame_pins_t  pins_q;
	logic [15:0] ctrl_q;
	logic [15:0] tx_word_q;
	logic [15:0] rx_word_q;
	logic [15:0] out_sr_q;
	logic [15:0] in_sr_q;
	logic [4:0]  bit_cnt_q;
	logic        byte_two_q;
	logic        secondary_q;
	logic        busy_q;
	logic [`IRQ_BITS-1:0] irq_stat_q;
	logic [`IRQ_BITS-1:0] irq_mask_q;
	logic [`IRQ_BITS-1:0] irq_set;
	logic [1:0]  mode_sync_q;
	logic [1:0]  fmt_sync_q;
	logic [1:0]  din_sync_q;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        start_req;
	logic        byte_mode;
	logic        dual_mode;
	logic [4:0]  frame_bits;

	// ----------------------------------------------------------------
	// Shift clock
	// ----------------------------------------------------------------

	// One divider feeds both data lines so bits stay aligned to the pin clock.
	shift_clk_gen u_sclk (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.sclk_o    (shift_clk_o),
		.rise_en_o (sclk_rise),
		.fall_en_o (sclk_fall)
	);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------

	// Straps and the data pin come from outside this clock, so two stages each.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mode_sync_q <= 2'h0;
			fmt_sync_q  <= 2'h0;
			din_sync_q  <= 2'h0;
		end else begin
			mode_sync_q <= {mode_sync_q[0], mode_ctrl_i};
			fmt_sync_q  <= {fmt_sync_q[0], word_byte_sel_i};
			din_sync_q  <= {din_sync_q[0], serial_data_in_i};
		end
	end

	// Mode high selects word or byte, low selects dual-word.
	assign dual_mode  = !mode_sync_q[1];
	assign byte_mode  = !dual_mode && !fmt_sync_q[1];
	assign frame_bits = byte_mode ? `BYTE_BITS : `WORD_BITS;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	assign start_req = reg_wr_i && (reg_addr_i == `OFS_TX_DATA);

	// Control word; bit eleven resets low and in dual-word mode is visible on the pin next cycle.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_q <= `CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == `OFS_CTRL) begin
			ctrl_q <= reg_wdata_i;
		end
	end

	// Transmit word written by software; a write also starts one frame, or a pair in byte format and dual-word mode.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_word_q <= 16'h0000;
		end else if (start_req && !busy_q) begin
			tx_word_q <= reg_wdata_i;
		end
	end

	// Read data stand in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`OFS_CTRL:     reg_rdata_o <= ctrl_q;
				`OFS_TX_DATA:  reg_rdata_o <= tx_word_q;
				`OFS_RX_DATA:  reg_rdata_o <= rx_word_q;
				`OFS_STATUS:   reg_rdata_o <= {13'h0000, byte_mode, dual_mode, busy_q};
				`OFS_IRQ_STAT: reg_rdata_o <= {14'h0000, irq_stat_q};
				`OFS_IRQ_MASK: reg_rdata_o <= {14'h0000, irq_mask_q};
				default:       reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------

	// Sticky status; a set in the same cycle as a write-one clear wins.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == `OFS_IRQ_MASK) begin
				irq_mask_q <= reg_wdata_i[`IRQ_BITS-1:0];
			end
			if (reg_wr_i && reg_addr_i == `OFS_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~reg_wdata_i[`IRQ_BITS-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set;
			end
		end
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------

	// Lead places the first bit, shift runs the frame, gap ends it, with the strobe outside dual-word mode.
	// In byte format a word takes two frames; in dual-word mode a secondary frame follows.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_q        <= codec_serial_pkg::ST_IDLE;
			busy_q      <= 1'b0;
			bit_cnt_q   <= 5'h00;
			byte_two_q  <= 1'b0;
			secondary_q <= 1'b0;
		end else begin
			unique case (st_q)
				codec_serial_pkg::ST_IDLE: begin
					if (start_req && !busy_q) begin
						busy_q      <= 1'b1;
						byte_two_q  <= 1'b0;
						secondary_q <= 1'b0;
						st_q        <= codec_serial_pkg::ST_LEAD;
					end
				end
				codec_serial_pkg::ST_LEAD: begin
					if (sclk_rise) begin
						bit_cnt_q <= 5'h00;
						st_q      <= codec_serial_pkg::ST_SHIFT;
					end
				end
				codec_serial_pkg::ST_SHIFT: begin
					// Rising edges are counted so the last input bit is taken before the syncs rise.
					if (sclk_rise) begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
						if (bit_cnt_q == frame_bits - 5'h01) begin
							st_q <= codec_serial_pkg::ST_GAP;
						end
					end
				end
				codec_serial_pkg::ST_GAP: begin
					if (sclk_rise) begin
						if (byte_mode && !byte_two_q) begin
							byte_two_q <= 1'b1;
							st_q       <= codec_serial_pkg::ST_LEAD;
						end else if (dual_mode && !secondary_q) begin
							secondary_q <= 1'b1;
							st_q        <= codec_serial_pkg::ST_LEAD;
						end else begin
							busy_q <= 1'b0;
							st_q   <= codec_serial_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Data shifting
	// ----------------------------------------------------------------

	// Output bits change on the falling edge; input bits are captured on the rising one.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_sr_q  <= 16'h0000;
			in_sr_q   <= 16'h0000;
			rx_word_q <= 16'h0000;
			serial_data_out_o <= 1'b0;
		end else begin
			if (st_q == codec_serial_pkg::ST_IDLE && start_req && !busy_q) begin
				out_sr_q <= rx_word_q ^ reg_wdata_i;
			end
			if (st_q == codec_serial_pkg::ST_LEAD) begin
				serial_data_out_o <= out_sr_q[15];
			end else if (st_q == codec_serial_pkg::ST_SHIFT && sclk_fall) begin
				out_sr_q          <= {out_sr_q[14:0], 1'b0};
				serial_data_out_o <= out_sr_q[14];
			end
			if (st_q == codec_serial_pkg::ST_SHIFT && sclk_rise) begin
				in_sr_q <= {in_sr_q[14:0], din_sync_q[1]};
			end
			if (st_q == codec_serial_pkg::ST_GAP && sclk_rise && !busy_q) begin
				rx_word_q <= in_sr_q;
			end else if (st_q == codec_serial_pkg::ST_GAP && sclk_rise && !secondary_q
				&& !(byte_mode && !byte_two_q)) begin
				rx_word_q <= in_sr_q;
			end
		end
	end

	// Completion events feed the sticky status bits.
	always_comb begin
		irq_set = 2'h0;
		if (st_q == codec_serial_pkg::ST_GAP && sclk_rise) begin
			irq_set[`IRQ_RX_DONE] = !(byte_mode && !byte_two_q);
			irq_set[`IRQ_TX_DONE] = !(byte_mode && !byte_two_q);
		end
	end

	// ----------------------------------------------------------------
	// Frame pins
	// ----------------------------------------------------------------

	// Both syncs low exactly while bits move; the first bit is already on the line.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pins_q <= '{rx_sync_n: 1'b1, tx_sync_n: 1'b1, sec_sync: 1'b1, rx_end_n: 1'b1};
		end else begin
			pins_q.rx_sync_n <= !(st_q == codec_serial_pkg::ST_SHIFT);
			pins_q.tx_sync_n <= !(st_q == codec_serial_pkg::ST_SHIFT);
			// Primary frames hold the secondary sync high; secondary ones copy transmit sync.
			if (dual_mode && secondary_q) begin
				pins_q.sec_sync <= !(st_q == codec_serial_pkg::ST_SHIFT);
			end else begin
				pins_q.sec_sync <= 1'b1;
			end
			// Word: one-cycle pulse at end; byte: low from first byte end to second.
			if (st_q == codec_serial_pkg::ST_GAP && sclk_rise && !dual_mode) begin
				pins_q.rx_end_n <= byte_mode ? byte_two_q : 1'b0;
			end else if (!byte_mode || st_q == codec_serial_pkg::ST_IDLE) begin
				pins_q.rx_end_n <= 1'b1;
			end
		end
	end

	assign receive_frame_sync_n_o  = pins_q.rx_sync_n;
	assign transmit_frame_sync_n_o = pins_q.tx_sync_n;
	assign secondary_frame_sync_o  = pins_q.sec_sync;
	assign receive_end_strobe_n_o  = pins_q.rx_end_n;
	// Only meaningful in dual-word mode; held low otherwise.
	assign aux_output_hi_o = dual_mode && ctrl_q[`CTRL_BIT_HI_POS];

endmodule

`default_nettype wire

// ===== src/codec_serial_regs.svh
// Offsets, field positions, reset values and timing counts of the codec serial frame block.
`ifndef CODEC_SERIAL_REGS_SVH
`define CODEC_SERIAL_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CTRL        4'h0
`define OFS_TX_DATA     4'h1
`define OFS_RX_DATA     4'h2
`define OFS_STATUS      4'h3
`define OFS_IRQ_STAT    4'h4
`define OFS_IRQ_MASK    4'h5

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_BIT_HI_POS 11
`define CTRL_START_POS  0
`define CTRL_RESET      16'h0000
`define IRQ_RX_DONE     0
`define IRQ_TX_DONE     1
`define IRQ_BITS        2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCLK_DIV        4'h3
`define WORD_BITS       5'h10
`define BYTE_BITS       5'h08

`endif

// ===== src/codec_serial_pkg.sv
// Types shared by the codec serial frame block.
package codec_serial_pkg;

	// Frame sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_SHIFT,
		ST_GAP
	} frame_state_t;

	// Frame sync outputs travelling together.
	typedef struct packed {
		logic rx_sync_n;
		logic tx_sync_n;
		logic sec_sync;
		logic rx_end_n;
	} frame_pins_t;

endpackage

// ===== src/shift_clk_gen.sv
// Shift clock divider producing edge enables and the shift clock pin.
`timescale 1ns/1ps
`default_nettype none
`include "codec_serial_regs.svh"

module shift_clk_gen (
	// Clock and reset.
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Divided outputs.
	output logic      sclk_o,
	output logic      rise_en_o,
	output logic      fall_en_o
);

	logic [3:0] cnt_q;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------

	// The pin toggles each time the counter wraps; the clock is held high in reset.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_q  <= 4'h0;
			sclk_o <= 1'b1;
		end else if (cnt_q == `SCLK_DIV) begin
			cnt_q  <= 4'h0;
			sclk_o <= ~sclk_o;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Enables mark the cycle on which the pin changes.
	assign rise_en_o = (cnt_q == `SCLK_DIV) && !sclk_o;
	assign fall_en_o = (cnt_q == `SCLK_DIV) && sclk_o;

endmodule

`default_nettype wire

// ===== test/codec_serial_frame_monitor.sv
// Port assertions of the codec serial frame block.
`timescale 1ns/1ps
`default_nettype none
module codec_serial_frame_monitor (
	// Clock, reset and inputs.
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        mode_ctrl_i,
	input wire logic        word_byte_sel_i,
	// Outputs.
	input wire logic        serial_data_out_o,
	input wire logic        receive_frame_sync_n_o,
	input wire logic        transmit_frame_sync_n_o,
	input wire logic        secondary_frame_sync_o,
	input wire logic        receive_end_strobe_n_o,
	input wire logic        aux_output_hi_o
);
	logic [2:0] word_q, byte_q, dual_q;
	logic [7:0] rx_low_q, tx_low_q;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// A mode counts after three steady samples, longer than the strap synchroniser.
	always_ff @(posedge ref_clk_i) begin
		word_q <= {word_q[1:0], mode_ctrl_i & word_byte_sel_i};
		byte_q <= {byte_q[1:0], mode_ctrl_i & ~word_byte_sel_i};
		dual_q <= {dual_q[1:0], ~mode_ctrl_i};
	end
	// Cycles each frame sync has been low so far.
	always_ff @(posedge ref_clk_i) begin
		rx_low_q <= receive_frame_sync_n_o ? 8'h00 : rx_low_q + 8'h01;
		tx_low_q <= transmit_frame_sync_n_o ? 8'h00 : tx_low_q + 8'h01;
	end
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_AUX_SET: assert property (
		reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[11] && &dual_q |=> aux_output_hi_o) else $error("aux stayed low");
	AST_AUX_CLR: assert property (
		reg_wr_i && reg_addr_i == 4'h0 && !reg_wdata_i[11] |=> !aux_output_hi_o) else $error("aux stayed high");
	AST_AUX_OFF: assert property (
		&(word_q | byte_q) |-> !aux_output_hi_o) else $error("aux high outside dual-word mode");
	AST_AUX_RST: assert property (
		$fell(rst_i) |-> !aux_output_hi_o) else $error("aux high after reset");
	AST_RX_LOW: assert property (
		$rose(receive_frame_sync_n_o) |-> rx_low_q == 8'h80 || rx_low_q == 8'h40) else $error("receive sync length");
	AST_TX_LOW: assert property (
		$rose(transmit_frame_sync_n_o) |-> tx_low_q == 8'h80 || tx_low_q == 8'h40) else $error("transmit sync length");
	AST_MSB_LEAD: assert property (
		$fell(receive_frame_sync_n_o) |-> $stable(serial_data_out_o)) else $error("first bit not set up early");
	AST_END_PULSE: assert property (
		$fell(receive_end_strobe_n_o) && &word_q |=> receive_end_strobe_n_o) else $error("end pulse too long");
	AST_END_AFTER: assert property (
		$rose(receive_frame_sync_n_o) && &word_q |-> ##[0:9] !receive_end_strobe_n_o) else $error("end pulse missing");
	AST_END_BYTE: assert property (
		&byte_q && !receive_end_strobe_n_o && !receive_frame_sync_n_o |=> !receive_end_strobe_n_o)
		else $error("end strobe rose inside second byte");
	AST_SEC_HIGH: assert property (
		&(word_q | byte_q) |-> secondary_frame_sync_o) else $error("secondary sync low");
	AST_SEC_COPY: assert property (
		!secondary_frame_sync_o |-> !transmit_frame_sync_n_o && $past(secondary_frame_sync_o) == $past(transmit_frame_sync_n_o))
		else $error("secondary sync differs from transmit sync");
endmodule
bind codec_serial_frame codec_serial_frame_monitor u_mon (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.mode_ctrl_i, .word_byte_sel_i, .serial_data_out_o, .receive_frame_sync_n_o, .transmit_frame_sync_n_o,
	.secondary_frame_sync_o, .receive_end_strobe_n_o, .aux_output_hi_o);
`default_nettype wire

// ===== test/host_serial_model.sv
// Behavioural host serial port trading words with the codec.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// Link.
	input  wire logic        shift_clk_i,
	input  wire logic        rx_sync_n_i,
	input  wire logic        tx_sync_n_i,
	input  wire logic        dev_data_i,
	output logic             dev_data_o,
	// Bench side.
	input  wire logic [15:0] tx_word_i,
	output logic      [15:0] rx_word_o,
	output logic      [7:0]  rx_bits_o
);
	logic       clk_p, rxs_p, txs_p, data_p;
	logic [3:0] idx;
	// Pins are watched with the fast clock; last edge's values mark each shift clock edge.
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			idx <= 4'h0;
			rx_bits_o <= 8'h00;
			rx_word_o <= 16'h0000;
			dev_data_o <= 1'b0;
		end else begin
			if (clk_p && !shift_clk_i && !rxs_p) begin
				rx_word_o <= {rx_word_o[14:0], data_p};
				rx_bits_o <= rx_bits_o + 8'h01;
			end
			// Bytes run on from the same index, so the high byte goes first.
			if (txs_p && !tx_sync_n_i) begin
				dev_data_o <= tx_word_i[4'hf - idx];
			end else if (!clk_p && shift_clk_i && !txs_p) begin
				dev_data_o <= tx_word_i[4'he - idx];
				idx <= idx + 4'h1;
			end else if (!txs_p && tx_sync_n_i) begin
				dev_data_o <= ~dev_data_o; // Released line must not keep the last bit.
			end
		end
		clk_p <= shift_clk_i;
		rxs_p <= rx_sync_n_i;
		txs_p <= tx_sync_n_i;
		data_p <= dev_data_i;
	end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the codec serial frame block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// One transfer: straps, word written to the transmit register, word the host sends.
	typedef struct packed {
		logic        mode;
		logic        sel;
		logic [15:0] tx;
		logic [15:0] host;
	} row_t;
	logic        ref_clk, rst, reg_wr, reg_rd, mode_ctrl, word_sel, sdi, sdo, sclk, rfs_n, tfs_n, sec, end_n, aux, irq;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, rdata, host_tx, host_rx, prev_rx;
	logic [7:0]  host_bits, b0;
	int          fails, comparisons, end_low, sec_low, n;
	row_t        rows [4];
	codec_serial_frame u_dut (.ref_clk_i(ref_clk), .rst_i(rst), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .mode_ctrl_i(mode_ctrl), .word_byte_sel_i(word_sel),
		.serial_data_in_i(sdi), .serial_data_out_o(sdo), .shift_clk_o(sclk), .receive_frame_sync_n_o(rfs_n),
		.transmit_frame_sync_n_o(tfs_n), .secondary_frame_sync_o(sec), .receive_end_strobe_n_o(end_n),
		.aux_output_hi_o(aux), .irq_o(irq));
	host_serial_model u_host (.ref_clk_i(ref_clk), .rst_i(rst), .shift_clk_i(sclk), .rx_sync_n_i(rfs_n),
		.tx_sync_n_i(tfs_n), .dev_data_i(sdo), .dev_data_o(sdi), .tx_word_i(host_tx), .rx_word_o(host_rx),
		.rx_bits_o(host_bits));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic look(input logic [15:0] seen, input logic [15:0] want);
		#1;
		chk(seen, want);
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] want);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(rdata, want);
		@(posedge ref_clk);
	endtask
	// Waits for sixteen host bits plus a tail, bounded, counting strobe low times.
	task automatic run(input int extra);
		int k;
		b0 = host_bits;
		end_low = 0;
		sec_low = 0;
		for (k = 0; k < 4000 && extra > 0; k++) begin
			@(posedge ref_clk);
			#1;
			end_low += int'(!end_n);
			sec_low += int'(!sec);
			if (8'(host_bits - b0) >= 8'h10) extra--;
		end
		look(16'(k < 4000), 16'h0001);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// The tests take under 20 us; fifteen times that means a hang.
	initial begin
		#300000;
		fails++;
		wrap_up();
	end
	// Ordinary transfers first, then back-to-back starts, dual-word mode and reset.
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		mode_ctrl = 1'b1;
		word_sel = 1'b1;
		host_tx = 16'h0000;
		prev_rx = 16'h0000;
		fails = 0;
		comparisons = 0;
		rows = '{'{1'b1, 1'b1, 16'ha5c3, 16'h0f1e}, '{1'b1, 1'b1, 16'h8001, 16'h7ffe},
			'{1'b1, 1'b0, 16'h1234, 16'hfedc}, '{1'b1, 1'b0, 16'h00ff, 16'h8100}};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		wr(4'h5, 16'h0003);
		for (n = 0; n < 4; n++) begin
			word_sel <= rows[n].sel;
			host_tx <= rows[n].host;
			repeat (4) @(posedge ref_clk);
			wr(4'h1, rows[n].tx);
			run(40);
			chk(host_rx, prev_rx ^ rows[n].tx);
			chk(16'(rows[n].sel ? end_low == 1 : end_low > 64), 16'h0001);
			rd(4'h2, rows[n].host);
			look(16'(irq), 16'h0001);
			wr(4'h4, 16'h0003);
			look(16'(irq), 16'h0000);
			prev_rx = rows[n].host;
			$display("transfer %0d done", n);
		end
		word_sel <= 1'b1;
		wr(4'h5, 16'h0000);
		reg_addr <= 4'h1;
		reg_wdata <= 16'h1234;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wdata <= 16'hffff;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		run(40);
		chk(host_rx, prev_rx ^ 16'h1234);
		look(16'(irq), 16'h0000);
		wr(4'h5, 16'h0001);
		look(16'(irq), 16'h0001);
		wr(4'h4, 16'h0003);
		look(16'(irq), 16'h0000);
		rd(4'hf, 16'h0000);
		rd(4'h3, 16'h0000);
		$display("busy and interrupt test done");
		mode_ctrl <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wr(4'h0, 16'h0800);
		look(16'(aux), 16'h0001);
		rd(4'h3, 16'h0002);
		wr(4'h1, 16'h0f0f);
		run(700);
		chk(16'(sec_low), 16'h0080);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(aux), 16'h0000);
		chk({14'h0000, sclk, rfs_n}, 16'h0003);
		@(posedge ref_clk);
		rst <= 1'b0;
		$display("dual-word and reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
